// File: hdl/ihbi_params.svh
/*
  Constants of the ISA host bus interface: address width, address window and wait-state timing counts.
  Assumes a 40 MHz core clock and bus strobes already synchronous to it.
*/
// Contract
// - Buffer direction low during CPU read only
// - Upper-byte buffer enable only for high-byte transfers
// - Byte-high enable ignored unless 16-bit mode
// - Refresh cycles block memory strobe response
// - Address captured while address latch enable high
// - Address enable high blocks I/O strobes
// - Ready pulled low to stretch memory cycles
// - I/O read and write strobes decoded
// - Memory read and write strobes decoded
// - System reset returns all logic to reset
`ifndef IHBI_PARAMS_SVH
`define IHBI_PARAMS_SVH

// ----------------------------------------
// Address window
// ----------------------------------------
`define IHBI_ADDR_W 19
`define IHBI_WIN_BASE 19'h00000
`define IHBI_WIN_MASK 19'h00000
// ----------------------------------------
// Wait-state timing
// ----------------------------------------
`define IHBI_WAIT_NS 100
`define IHBI_CLK_NS 25
`define IHBI_WAIT_CYC ((`IHBI_WAIT_NS + `IHBI_CLK_NS - 1) / `IHBI_CLK_NS)
`define IHBI_CNT_W 4

`endif

// File: hdl/ihbi_pkg.sv
/*
  Types of the ISA host bus interface.
  Assumes ihbi_params.svh is included before use.
*/
`include "ihbi_params.svh"
package ihbi_pkg;
  typedef enum logic [1:0] {
    IHBI_IDLE = 2'b00,
    IHBI_WAIT = 2'b01,
    IHBI_DONE = 2'b11
  } ihbi_state_t;
endpackage

// File: hdl/ihbi_decode.sv
/*
  Combinational strobe qualification of the ISA bus.
  Assumes strobes are synchronous to the core clock.
*/
`include "ihbi_params.svh"
module ihbi_decode
  import ihbi_pkg::*;
(
  input wire logic cs_i,
  input wire logic aen_i,
  input wire logic ref_n_i,
  input wire logic iord_n_i,
  input wire logic iowr_n_i,
  input wire logic memr_n_i,
  input wire logic memw_n_i,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic mem_rd_o,
  output logic mem_wr_o
);
  logic mem_ok;
  assign mem_ok = cs_i && ref_n_i;
  assign io_rd_o = !iord_n_i && !aen_i;
  assign io_wr_o = !iowr_n_i && !aen_i;
  assign mem_rd_o = !memr_n_i && mem_ok;
  assign mem_wr_o = !memw_n_i && mem_ok;
endmodule // ihbi_decode

// File: hdl/ihbi_top.sv
/*
  ISA host bus interface: decodes cycles, steers data buffers, drives 16-bit acknowledge and ready.
  Assumes bus inputs are synchronous to clk_i; the bench resolves tristate lines from the enables.
*/
`include "ihbi_params.svh"
module ihbi_top
  import ihbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_i,
  input wire logic [`IHBI_ADDR_W-1:0] addr_i,
  input wire logic sbhe_n_i,
  input wire logic iord_n_i,
  input wire logic iowr_n_i,
  input wire logic memr_n_i,
  input wire logic memw_n_i,
  input wire logic ref_n_i,
  input wire logic bale_i,
  input wire logic aen_i,
  input wire logic mode16_i,
  input wire logic wait_req_i,
  output logic dir_o,
  output logic upper_byte_buffer_enable_n_o,
  output logic memcs16_n_o,
  output logic memcs16_oe_n_o,
  output logic iochrdy_o,
  output logic iochrdy_oe_n_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [`IHBI_ADDR_W-1:0] mem_addr_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ihbi_state_t st;
    logic [`IHBI_CNT_W-1:0] cnt;
    logic [`IHBI_ADDR_W-1:0] addr;
    logic dir;
    logic ube_n;
    logic cs16_oe_n;
    logic rdy_oe_n;
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
  } ihbi_regs_t;

  ihbi_regs_t s_r;
  ihbi_regs_t s_nxt;
  logic dio_rd;
  logic dio_wr;
  logic dmem_rd;
  logic dmem_wr;
  logic in_win;
  logic mem_cyc;

  function automatic logic ihbi_hit(input logic [`IHBI_ADDR_W-1:0] a);
    ihbi_hit = ((a & `IHBI_WIN_MASK) == `IHBI_WIN_BASE);
  endfunction

  ihbi_decode u_dec (
    .cs_i(cs_i),
    .aen_i(aen_i),
    .ref_n_i(ref_n_i),
    .iord_n_i(iord_n_i),
    .iowr_n_i(iowr_n_i),
    .memr_n_i(memr_n_i),
    .memw_n_i(memw_n_i),
    .io_rd_o(dio_rd),
    .io_wr_o(dio_wr),
    .mem_rd_o(dmem_rd),
    .mem_wr_o(dmem_wr)
  );

  assign mem_cyc = dmem_rd || dmem_wr;
  assign in_win = ihbi_hit(bale_i ? addr_i : s_r.addr);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    if (bale_i)
    begin
      s_nxt.addr = addr_i;
    end
    s_nxt.io_rd = dio_rd;
    s_nxt.io_wr = dio_wr;
    s_nxt.mem_rd = dmem_rd;
    s_nxt.mem_wr = dmem_wr;
    s_nxt.dir = !(dio_rd || dmem_rd);
    s_nxt.ube_n = !(mode16_i && !sbhe_n_i && (dio_rd || dio_wr || mem_cyc));
    s_nxt.cs16_oe_n = !(mode16_i && cs_i && ref_n_i && in_win);
    case (s_r.st)
      IHBI_IDLE:
      begin
        s_nxt.rdy_oe_n = 1'b1;
        if (mem_cyc && wait_req_i)
        begin
          s_nxt.st = IHBI_WAIT;
          s_nxt.cnt = `IHBI_CNT_W'(`IHBI_WAIT_CYC);
          s_nxt.rdy_oe_n = 1'b0;
        end
      end
      IHBI_WAIT:
      begin
        if (s_r.cnt > `IHBI_CNT_W'(1))
        begin
          s_nxt.cnt = s_r.cnt - `IHBI_CNT_W'(1);
        end
        else
        begin
          s_nxt.st = IHBI_DONE;
          s_nxt.rdy_oe_n = 1'b1;
        end
      end
      IHBI_DONE:
      begin
        s_nxt.rdy_oe_n = 1'b1;
        if (!mem_cyc)
        begin
          s_nxt.st = IHBI_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = IHBI_IDLE;
        s_nxt.rdy_oe_n = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_r <= '{st: IHBI_IDLE, cnt: '0, addr: '0, dir: 1'b1, ube_n: 1'b1, cs16_oe_n: 1'b1,
               rdy_oe_n: 1'b1, io_rd: 1'b0, io_wr: 1'b0, mem_rd: 1'b0, mem_wr: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign dir_o = s_r.dir;
  assign upper_byte_buffer_enable_n_o = s_r.ube_n;
  // Driven level is low whenever its enable is active, both taken from the same flop
  assign memcs16_n_o = s_r.cs16_oe_n;
  assign memcs16_oe_n_o = s_r.cs16_oe_n;
  assign iochrdy_o = s_r.rdy_oe_n;
  assign iochrdy_oe_n_o = s_r.rdy_oe_n;
  assign io_rd_o = s_r.io_rd;
  assign io_wr_o = s_r.io_wr;
  assign mem_rd_o = s_r.mem_rd;
  assign mem_wr_o = s_r.mem_wr;
  assign mem_addr_o = s_r.addr;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_io_dma;
    @(posedge clk_i) disable iff (!rst_b_i) aen_i |=> !io_rd_o && !io_wr_o;
  endproperty
  a_io_dma: assert property (p_io_dma) else $error("io strobe during dma");

  property p_ref_block;
    @(posedge clk_i) disable iff (!rst_b_i) !ref_n_i |=> !mem_rd_o && !mem_wr_o && memcs16_oe_n_o;
  endproperty
  a_ref_block: assert property (p_ref_block) else $error("memory response in refresh");

  property p_cs_block;
    @(posedge clk_i) disable iff (!rst_b_i) !cs_i |=> !mem_rd_o && !mem_wr_o;
  endproperty
  a_cs_block: assert property (p_cs_block) else $error("memory strobe without select");

  property p_dir;
    @(posedge clk_i) disable iff (!rst_b_i) (!iord_n_i && !aen_i) |=> !dir_o;
  endproperty
  a_dir: assert property (p_dir) else $error("dir not low in read");

  property p_ube_8bit;
    @(posedge clk_i) disable iff (!rst_b_i) !mode16_i |=> upper_byte_buffer_enable_n_o;
  endproperty
  a_ube_8bit: assert property (p_ube_8bit) else $error("upper byte in 8-bit mode");

  property p_ube_need;
    @(posedge clk_i) disable iff (!rst_b_i) sbhe_n_i |=> upper_byte_buffer_enable_n_o;
  endproperty
  a_ube_need: assert property (p_ube_need) else $error("upper byte without high byte");

  property p_cs16;
    @(posedge clk_i) disable iff (!rst_b_i) !memcs16_oe_n_o |-> $past(mode16_i) && $past(cs_i);
  endproperty
  a_cs16: assert property (p_cs16) else $error("16-bit ack without mode");

  property p_rdy_len;
    @(posedge clk_i) disable iff (!rst_b_i) $fell(iochrdy_oe_n_o) |-> !iochrdy_oe_n_o [*4] ##1 iochrdy_oe_n_o;
  endproperty
  a_rdy_len: assert property (p_rdy_len) else $error("ready stretch length wrong");

  property p_mem_dec;
    @(posedge clk_i) disable iff (!rst_b_i) (!memw_n_i && cs_i && ref_n_i) |=> mem_wr_o;
  endproperty
  a_mem_dec: assert property (p_mem_dec) else $error("memory write missed");
endmodule // ihbi_top

// File: verif/ihbi_host_model.sv
/*
  Host side of the bus: drives qualifiers and strobes, resolves the shared lines.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`include "ihbi_params.svh"
module ihbi_host_model
(
  input wire logic memcs16_n_i,
  input wire logic memcs16_oe_n_i,
  input wire logic iochrdy_i,
  input wire logic iochrdy_oe_n_i,
  output logic cs_o,
  output logic [`IHBI_ADDR_W-1:0] addr_o,
  output logic sbhe_n_o,
  output logic iord_n_o,
  output logic iowr_n_o,
  output logic memr_n_o,
  output logic memw_n_o,
  output logic ref_n_o,
  output logic bale_o,
  output logic aen_o,
  output logic mode16_o,
  output logic wait_req_o,
  output wire memcs16_w_o,
  output wire iochrdy_w_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Shared lines pulled up when released
  // ----------------------------------------
  assign memcs16_w_o = memcs16_oe_n_i ? 1'b1 : memcs16_n_i;
  assign iochrdy_w_o = iochrdy_oe_n_i ? 1'b1 : iochrdy_i;

  task automatic qual(input logic cs, aen, rf, m16, sb, wr, bl, input logic [`IHBI_ADDR_W-1:0] a);
    cs_o = cs;
    aen_o = aen;
    ref_n_o = rf;
    mode16_o = m16;
    sbhe_n_o = sb;
    wait_req_o = wr;
    bale_o = bl;
    addr_o = a;
  endtask

  task automatic strobe(input logic [3:0] s);
    {iord_n_o, iowr_n_o, memr_n_o, memw_n_o} = s;
  endtask
endmodule // ihbi_host_model

// File: verif/isa_host_bus_interface_tb.sv
/*
  Self-checking bench of the ISA host bus interface.
  Assumes the host model drives all bus inputs and pulls the shared lines up.
*/
`include "ihbi_params.svh"
`define CHK(n, e, a) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("wrong value %s expected %h seen %h", n, e, a); \
    end \
  end
module isa_host_bus_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  int num_errors = 0;
  int comparisons = 0;
  logic cs, sbhe_n, iord_n, iowr_n, memr_n, memw_n, ref_n, bale, aen, m16, wreq;
  logic [`IHBI_ADDR_W-1:0] addr, maddr;
  logic dir, ube_n, mcs_n, mcs_oe_n, rdy, rdy_oe_n, io_rd, io_wr, mem_rd, mem_wr;
  wire mcs_w, rdy_w;

  ihbi_host_model host (.memcs16_n_i(mcs_n), .memcs16_oe_n_i(mcs_oe_n), .iochrdy_i(rdy),
    .iochrdy_oe_n_i(rdy_oe_n), .cs_o(cs), .addr_o(addr), .sbhe_n_o(sbhe_n), .iord_n_o(iord_n),
    .iowr_n_o(iowr_n), .memr_n_o(memr_n), .memw_n_o(memw_n), .ref_n_o(ref_n), .bale_o(bale),
    .aen_o(aen), .mode16_o(m16), .wait_req_o(wreq), .memcs16_w_o(mcs_w), .iochrdy_w_o(rdy_w));

  ihbi_top dut (.clk_i(clk), .rst_b_i(rst_b), .cs_i(cs), .addr_i(addr), .sbhe_n_i(sbhe_n),
    .iord_n_i(iord_n), .iowr_n_i(iowr_n), .memr_n_i(memr_n), .memw_n_i(memw_n), .ref_n_i(ref_n),
    .bale_i(bale), .aen_i(aen), .mode16_i(m16), .wait_req_i(wreq), .dir_o(dir),
    .upper_byte_buffer_enable_n_o(ube_n), .memcs16_n_o(mcs_n), .memcs16_oe_n_o(mcs_oe_n),
    .iochrdy_o(rdy), .iochrdy_oe_n_o(rdy_oe_n), .io_rd_o(io_rd), .io_wr_o(io_wr),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_addr_o(maddr));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic mem_stretch();
    int cnt;
    cnt = 0;
    host.qual(1, 0, 1, 0, 1, 1, 0, 19'h00000);
    host.strobe(4'hd);
    step(1);
    `CHK("mem_rd", 1'b1, mem_rd)
    `CHK("dir", 1'b0, dir)
    while (rdy_w === 1'b0 && cnt < 10)
    begin
      cnt++;
      step(1);
    end
    `CHK("stretch", 4, cnt)
    `CHK("rdy_oe_n", 1'b1, rdy_oe_n)
    if (cnt == 10)
      give_verdict();
    host.strobe(4'hf);
    step(2);
    `CHK("dir", 1'b1, dir)
  endtask

  task automatic mem_refuse();
    for (int i = 0; i < 4; i++)
    begin
      host.qual(i[1], 0, i[0], 0, 1, 0, 0, 19'h00000);
      host.strobe(4'he);
      step(1);
      `CHK("mem_wr", i == 3, mem_wr)
      host.strobe(4'hf);
      step(1);
    end
  endtask

  task automatic io_cycles();
    for (int i = 0; i < 4; i++)
    begin
      host.qual(0, i[1], 1, 0, 1, 0, 0, 19'h00000);
      host.strobe(i[0] ? 4'h7 : 4'hb);
      step(1);
      `CHK("io_rd", !i[1] && i[0], io_rd)
      `CHK("io_wr", !i[1] && !i[0], io_wr)
      host.strobe(4'hf);
      step(1);
    end
  endtask

  task automatic mem_sweep();
    logic hit;
    for (int i = 0; i < 32; i++)
    begin
      hit = i[0] && i[1];
      host.qual(i[0], 0, i[1], i[2], i[3], 0, 0, 19'(i));
      host.strobe({2'b11, !i[4], i[4]});
      step(1);
      `CHK("sw_mem_rd", hit && i[4], mem_rd)
      `CHK("sw_mem_wr", hit && !i[4], mem_wr)
      `CHK("sw_dir", !(hit && i[4]), dir)
      `CHK("sw_ube_n", !(hit && i[2] && !i[3]), ube_n)
      `CHK("sw_memcs16", !(hit && i[2]), mcs_w)
      `CHK("sw_iochrdy", 1'b1, rdy_w)
      host.strobe(4'hf);
      step(1);
    end
  endtask

  task automatic wide();
    for (int i = 0; i < 3; i++)
    begin
      host.qual(1, 0, 1, i != 0, i == 2, 0, 1, 19'h00000);
      host.strobe(4'hd);
      step(1);
      `CHK("ube_n", i != 1, ube_n)
      `CHK("memcs16", i == 0, mcs_w)
      host.strobe(4'hf);
      step(1);
    end
  endtask

  task automatic latch_and_reset();
    host.qual(1, 0, 1, 1, 0, 0, 1, 19'h5a5a5);
    host.strobe(4'hd);
    step(1);
    `CHK("addr", 19'h5a5a5, maddr)
    host.qual(1, 0, 1, 1, 0, 0, 0, 19'h12345);
    step(1);
    `CHK("addr", 19'h5a5a5, maddr)
    rst_b = 1'b0;
    #1;
    `CHK("rst_mem_rd", 1'b0, mem_rd)
    `CHK("rst_dir", 1'b1, dir)
    `CHK("rst_ube_n", 1'b1, ube_n)
    `CHK("rst_addr", 19'h00000, maddr)
    host.strobe(4'hf);
    step(1);
    rst_b = 1'b1;
    step(1);
    `CHK("post_rst_memcs16", 1'b0, mcs_w)
    `CHK("post_rst_dir", 1'b1, dir)
  endtask

  initial
  begin
    host.qual(0, 0, 1, 0, 1, 0, 0, 19'h00000);
    host.strobe(4'hf);
    repeat (20) @(posedge clk);
    #2;
    rst_b = 1'b1;
    step(1);
    mem_stretch();
    mem_refuse();
    io_cycles();
    mem_sweep();
    wide();
    latch_and_reset();
    give_verdict();
  end
endmodule // isa_host_bus_interface_tb
